// [src/aoms_seq.sv]
// converter operating mode sequencer with Avalon-MM register slave
//
// Behaviour
// - operating mode lives in control register bits 5 to 2.
// - mode 0000 is continuous conversion and the reset default.
// - mode 0001 powers up and runs one conversion over full settling time.
// - single conversion end loads data, drives ready flag low, goes to standby.
// - result and low ready flag hold until data read or new conversion.
// - finishing a data register read drives the ready flag high.
// - standby 0010 keeps all configuration registers while converter is off.
// - reference, oscillator, low-side switch, bias stay switchable in standby.
// - enabled diagnostics keep running in idle mode.
// - clock-needing diagnostics enabled during standby never run; enable them in continuous or idle mode.
// - mode 0011 powers everything down and registers lose contents.
// - idle 0100 holds filter and modulator in reset, clocks running.
// - calibration raises ready flag at start, lowers at end, then idle.
// - mode 0101 shorts input, one settling period, stores channel offset.
// - mode 0110 applies full-scale, four settling periods, stores channel gain.
// - mode 0111 measures system zero for one period into channel offset.
// - mode 1000 measures system full-scale for one period into channel gain.
//
// register words, values in bits 23:0:
//   0x00 control: mode 5:2, standby switches 11:8
//   0x04 status: ready 0, state 3:1, armed checks 8:4
//   0x08 result, read only; a read releases the flag
//   0x0C diagnostic enables
//   0x10 channel select
//   0x20 + 4 * ch offset, 0x40 + 4 * ch gain
//   codes above 1000 are dropped whole, switches too
//   state codes: 0 off, 1 standby, 2 idle, 3 conversion, 4 calibration
//
// Design decisions made here: the register addresses and the Avalon-MM register port.

`timescale 1ns/1ns
`include "aoms_regs.svh"

module aoms_seq #(
    parameter int NCH           = 4,
    parameter int SETTLE_CYCLES = `AOMS_SETTLE_CYC
) (
    input  wire logic               clk_sys,          // system clock, 50 MHz
    input  wire logic               reset_n,          // async reset, active low
    input  wire logic [7:0]         avs_address,      // byte address
    input  wire logic               avs_read,         // read request
    input  wire logic               avs_write,        // write request
    input  wire logic [31:0]        avs_writedata,    // write data
    output logic [31:0]             avs_readdata,     // read data
    output logic                    avs_waitrequest,  // stall while high
    input  wire logic [23:0]        adc_result,       // filter output word
    output logic [$clog2(NCH)-1:0]  adc_ch_sel,       // channel being measured
    output logic                    conv_ready_n,     // ready flag, low when data ready
    output aoms_pkg::aoms_afe_t     afe_ctl,          // front-end steering
    output aoms_pkg::aoms_pwr_t     pwr_ctl,          // standby-switchable blocks
    output logic [`AOMS_DIAG_W-1:0] diag_run          // clocked diagnostics active
);
    import aoms_pkg::*;

    localparam int CW = $clog2(NCH);

    // a job lasts as many edges as its count
    localparam logic [19:0] SETTLE_1 = 20'(SETTLE_CYCLES);
    localparam logic [19:0] SETTLE_4 = 20'(`AOMS_GAIN_PERIODS * SETTLE_CYCLES);

    // range decode of a per-channel block
    function automatic logic ch_hit(
        input logic [7:0] a,     // byte address
        input logic [7:0] base   // first channel word
    );
        ch_hit = (a[7:2] >= base[7:2]) && (a[7:2] < base[7:2] + 6'(NCH));
    endfunction

    // bus state
    logic                    ack_r;
    logic [31:0]             rdata_r;

    // sequencer state
    aoms_state_t             state_r, state_nxt;
    aoms_mode_t              mode_r, mode_nxt;
    logic [19:0]             cnt_r, cnt_nxt;
    logic                    rdy_n_r, rdy_n_nxt;
    logic [23:0]             data_r;
    aoms_pwr_t               pwr_r;
    logic [CW-1:0]           chsel_r;
    logic [`AOMS_DIAG_W-1:0] diag_en_r;
    logic [`AOMS_DIAG_W-1:0] diag_arm_r;

    // one coefficient pair per channel
    logic [23:0]             offs_r [NCH];
    logic [23:0]             gain_r [NCH];

    // access decode: a request is taken at the edge where waitrequest is low
    wire        req       = avs_read | avs_write;
    wire        wr_acc    = avs_write & ack_r;
    wire        rd_acc    = avs_read & ack_r;
    // one word per register, coefficients by range
    wire        hit_ctrl  = avs_address == `AOMS_CTRL_OFS;
    wire        hit_stat  = avs_address == `AOMS_STATUS_OFS;
    wire        hit_data  = avs_address == `AOMS_DATA_OFS;
    wire        hit_diag  = avs_address == `AOMS_DIAG_OFS;
    wire        hit_chsel = avs_address == `AOMS_CHSEL_OFS;
    wire        hit_offs  = ch_hit(avs_address, `AOMS_OFFS_BASE);
    wire        hit_gain  = ch_hit(avs_address, `AOMS_GAIN_BASE);
    wire [CW-1:0] acc_ch  = avs_address[CW+1:2];

    wire [3:0]  wr_mode   = avs_writedata[`AOMS_MODE_MSB:`AOMS_MODE_LSB];
    wire        mode_ok   = wr_mode <= MODE_SYS_GAIN;
    wire        start     = wr_acc & hit_ctrl & mode_ok;
    wire        pd_wipe   = start & (wr_mode == MODE_PDOWN);
    wire        awake     = state_r != ST_PDOWN;
    wire        cfg_wr    = wr_acc & awake;

    // a new mode write beats a job ending with it
    wire        busy      = (state_r == ST_CONV) || (state_r == ST_CAL);
    wire        last      = busy && (cnt_r == 20'h00001) && !start;
    wire        conv_done = last && (state_r == ST_CONV);
    wire        cal_done  = last && (state_r == ST_CAL);

    wire        data_read = rd_acc & hit_data;

    wire        clk_mode  = (mode_r == MODE_CONT) || (mode_r == MODE_IDLE);
    wire        cal_ofs   = (mode_r == MODE_INT_OFS) || (mode_r == MODE_SYS_OFS);
    wire        cal_gain  = (mode_r == MODE_INT_GAIN) || (mode_r == MODE_SYS_GAIN);

    // mode sequencing
    // the count only runs while a job is busy
    always_comb begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        cnt_nxt   = (busy && cnt_r != 20'h0) ? cnt_r - 20'h00001 : cnt_r;

        if (start) begin
            mode_nxt = aoms_mode_t'(wr_mode);
            case (aoms_mode_t'(wr_mode))
                MODE_CONT, MODE_SINGLE: begin
                    state_nxt = ST_CONV;
                    cnt_nxt   = SETTLE_1;
                end
                MODE_STANDBY: begin
                    state_nxt = ST_STBY;
                end
                MODE_PDOWN: begin
                    state_nxt = ST_PDOWN;
                end
                MODE_IDLE: begin
                    state_nxt = ST_IDLE;
                end
                MODE_INT_GAIN: begin
                    state_nxt = ST_CAL;
                    cnt_nxt   = SETTLE_4;
                end
                MODE_INT_OFS, MODE_SYS_OFS, MODE_SYS_GAIN: begin
                    state_nxt = ST_CAL;
                    cnt_nxt   = SETTLE_1;
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end else if (conv_done) begin
            // a single conversion parks in standby
            if (mode_r == MODE_SINGLE) begin
                state_nxt = ST_STBY;
                mode_nxt  = MODE_STANDBY;
            end else begin
                // continuous mode restarts at once
                cnt_nxt   = SETTLE_1;
            end
        end else if (cal_done) begin
            // a calibration parks in idle
            state_nxt = ST_IDLE;
            mode_nxt  = MODE_IDLE;
        end
    end

    // ready flag: completion lowering it wins over a read raising it
    // standby and idle writes leave it alone
    always_comb begin
        rdy_n_nxt = rdy_n_r;
        if (conv_done || cal_done) begin
            rdy_n_nxt = 1'b0;
        end else if (pd_wipe) begin
            rdy_n_nxt = 1'b1;
        end else if (start && wr_mode != MODE_STANDBY && wr_mode != MODE_IDLE) begin
            rdy_n_nxt = 1'b1;
        end else if (data_read) begin
            rdy_n_nxt = 1'b1;
        end
    end

    // reset lands in continuous conversion
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_CONV;
            mode_r  <= MODE_CONT;
            cnt_r   <= SETTLE_1;
            rdy_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt;
            cnt_r   <= cnt_nxt;
            rdy_n_r <= rdy_n_nxt;
        end
    end

    // configuration registers; power-down wipes them, standby leaves them alone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_r    <= 24'h000000;
            pwr_r     <= '0;
            chsel_r   <= '0;
            diag_en_r <= '0;
        end else if (pd_wipe) begin
            data_r    <= 24'h000000;
            pwr_r     <= '0;
            chsel_r   <= '0;
            diag_en_r <= '0;
        end else begin
            if (conv_done) begin
                data_r <= adc_result;
            end

            // switches ride on an accepted mode write only
            if (start) begin
                pwr_r <= avs_writedata[`AOMS_PWR_MSB:`AOMS_PWR_LSB];
            end

            if (cfg_wr && hit_chsel) begin
                chsel_r <= avs_writedata[CW-1:0];
            end

            if (cfg_wr && hit_diag) begin
                diag_en_r <= avs_writedata[`AOMS_DIAG_W-1:0];
            end
        end
    end

    // a diagnostic only arms if switched on while the mode is continuous or idle
    genvar gi;
    generate
        for (gi = 0; gi < `AOMS_DIAG_W; gi++) begin : g_diag
            // a bit set in standby stays dark until cleared and set again in continuous or idle mode
            wire dwr = cfg_wr && hit_diag;
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    diag_arm_r[gi] <= 1'b0;
                end else if (pd_wipe || (dwr && !avs_writedata[gi])) begin
                    diag_arm_r[gi] <= 1'b0;
                end else if (dwr && !diag_en_r[gi]) begin
                    diag_arm_r[gi] <= clk_mode;
                end
            end
        end

        // calibration coefficients per channel, writable by software too
        for (gi = 0; gi < NCH; gi++) begin : g_coef
            wire sel = chsel_r == CW'(gi);
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    offs_r[gi] <= `AOMS_OFFS_RST;
                    gain_r[gi] <= `AOMS_GAIN_RST;
                end else if (pd_wipe) begin
                    offs_r[gi] <= `AOMS_OFFS_RST;
                    gain_r[gi] <= `AOMS_GAIN_RST;
                end else begin
                    // a calibration result beats a software write
                    if (cal_done && cal_ofs && sel) begin
                        offs_r[gi] <= adc_result;
                    end else if (cfg_wr && hit_offs && acc_ch == CW'(gi)) begin
                        offs_r[gi] <= avs_writedata[23:0];
                    end

                    if (cal_done && cal_gain && sel) begin
                        gain_r[gi] <= adc_result;
                    end else if (cfg_wr && hit_gain && acc_ch == CW'(gi)) begin
                        gain_r[gi] <= avs_writedata[23:0];
                    end
                end
            end
        end
    endgenerate

    // read mux; unmapped addresses read zero and ignore writes
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;

        if (hit_ctrl) begin
            rd_mux[`AOMS_MODE_MSB:`AOMS_MODE_LSB] = mode_r;
            rd_mux[`AOMS_PWR_MSB:`AOMS_PWR_LSB]   = pwr_r;
        end else if (hit_stat) begin
            // bit 0 mirrors the flag pin, low when ready
            rd_mux[0]   = rdy_n_r;
            rd_mux[3:1] = state_r;
            rd_mux[8:4] = diag_arm_r;
        end else if (hit_data) begin
            rd_mux[23:0] = data_r;
        end else if (hit_diag) begin
            rd_mux[`AOMS_DIAG_W-1:0] = diag_en_r;
        end else if (hit_chsel) begin
            rd_mux[CW-1:0] = chsel_r;
        end else if (hit_offs) begin
            rd_mux[23:0] = offs_r[acc_ch];
        end else if (hit_gain) begin
            rd_mux[23:0] = gain_r[acc_ch];
        end
    end

    // one wait cycle per access so read data comes from a flop
    // waitrequest drops one cycle after a request rises
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r   <= req & ~ack_r;
            if (avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign avs_waitrequest     = req & ~ack_r;
    assign avs_readdata        = rdata_r;

    assign adc_ch_sel          = chsel_r;
    assign conv_ready_n        = rdy_n_r;
    assign pwr_ctl             = pwr_r;
    assign diag_run            = diag_arm_r & {`AOMS_DIAG_W{awake}};

    // steering follows state with no extra cycle
    assign afe_ctl.mod_reset     = !busy;
    assign afe_ctl.mod_clk_en    = busy || (state_r == ST_IDLE);
    assign afe_ctl.analog_pwr_en = busy;
    assign afe_ctl.core_clk_en   = awake;

    assign afe_ctl.input_short   = (state_r == ST_CAL) && (mode_r == MODE_INT_OFS);
    assign afe_ctl.fullscale_in  = (state_r == ST_CAL) && (mode_r == MODE_INT_GAIN);

endmodule

// [src/aoms_regs.svh]
// register offsets, field positions, reset values and timing counts of the mode sequencer
`ifndef AOMS_REGS_SVH
`define AOMS_REGS_SVH

`define AOMS_CTRL_OFS      8'h00
`define AOMS_STATUS_OFS    8'h04
`define AOMS_DATA_OFS      8'h08
`define AOMS_DIAG_OFS      8'h0C
`define AOMS_CHSEL_OFS     8'h10
`define AOMS_OFFS_BASE     8'h20
`define AOMS_GAIN_BASE     8'h40

`define AOMS_MODE_LSB      2
`define AOMS_MODE_MSB      5
`define AOMS_PWR_LSB       8
`define AOMS_PWR_MSB       11
`define AOMS_DIAG_W        5

`define AOMS_OFFS_RST      24'h800000
`define AOMS_GAIN_RST      24'h500000
`define AOMS_MODE_RST      4'h0

`define AOMS_CLK_NS        20
`define AOMS_SETTLE_NS     2560
`define AOMS_SETTLE_CYC    ((`AOMS_SETTLE_NS + `AOMS_CLK_NS - 1) / `AOMS_CLK_NS)
`define AOMS_GAIN_PERIODS  4

`endif

// [src/aoms_pkg.sv]
// types shared by the operating mode sequencer
package aoms_pkg;

    typedef enum logic [3:0] {
        MODE_CONT     = 4'h0,
        MODE_SINGLE   = 4'h1,
        MODE_STANDBY  = 4'h2,
        MODE_PDOWN    = 4'h3,
        MODE_IDLE     = 4'h4,
        MODE_INT_OFS  = 4'h5,
        MODE_INT_GAIN = 4'h6,
        MODE_SYS_OFS  = 4'h7,
        MODE_SYS_GAIN = 4'h8
    } aoms_mode_t;

    typedef enum logic [2:0] {
        ST_PDOWN = 3'h0,
        ST_STBY  = 3'h1,
        ST_IDLE  = 3'h2,
        ST_CONV  = 3'h3,
        ST_CAL   = 3'h4
    } aoms_state_t;

    // standby-controllable analog blocks
    typedef struct packed {
        logic bias_en;
        logic lsw_en;
        logic osc_en;
        logic ref_en;
    } aoms_pwr_t;

    // analog front-end steering
    typedef struct packed {
        logic mod_reset;
        logic mod_clk_en;
        logic analog_pwr_en;
        logic core_clk_en;
        logic input_short;
        logic fullscale_in;
    } aoms_afe_t;

endpackage

// [tb/aoms_seq_chk.sv]
// port assertions for the operating mode sequencer
`timescale 1ns/1ns
`include "aoms_regs.svh"
module aoms_seq_chk #(
    parameter int SETTLE_CYCLES = 4
) (
    input wire logic                   clk_sys,         // system clock
    input wire logic                   reset_n,         // async reset, active low
    input wire logic [7:0]             avs_address,     // byte address
    input wire logic                   avs_read,        // read request
    input wire logic                   avs_write,       // write request
    input wire logic [31:0]            avs_writedata,   // write data
    input wire logic                   avs_waitrequest, // stall
    input wire logic                   conv_ready_n,    // ready flag
    input wire aoms_pkg::aoms_afe_t    afe_ctl,         // front-end steering
    input wire aoms_pkg::aoms_pwr_t    pwr_ctl,         // standby blocks
    input wire logic [`AOMS_DIAG_W-1:0] diag_run        // diagnostics active
);
    import aoms_pkg::*;
    wire        ctl_wr = avs_write && !avs_waitrequest && avs_address == `AOMS_CTRL_OFS;
    wire        dat_rd = avs_read && !avs_waitrequest && avs_address == `AOMS_DATA_OFS;
    wire [3:0]  wmode  = avs_writedata[5:2];
    wire [3:0]  pwr_w  = avs_writedata[11:8];
    logic [3:0]  last_mode_r;
    logic [15:0] since_r;
    // cycles since the last accepted mode write; saturates so it never wraps
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_mode_r <= 4'h0;
            since_r     <= 16'h0;
        end else if (ctl_wr && wmode <= 4'h8) begin
            last_mode_r <= wmode;
            since_r     <= 16'h1;
        end else if (since_r != 16'hFFFF) begin
            since_r     <= since_r + 16'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_start_rdy;
        ctl_wr && wmode inside {4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8} |=> conv_ready_n;
    endproperty
    a_start_rdy: assert property (p_start_rdy) else $error("ready flag not raised at start");
    property p_done_time;
        $fell(conv_ready_n) && last_mode_r inside {4'h1, 4'h5, 4'h7, 4'h8} |-> since_r == SETTLE_CYCLES + 1;
    endproperty
    a_done_time: assert property (p_done_time) else $error("one-period operation wrong length");
    property p_gain_time;
        $fell(conv_ready_n) && last_mode_r == 4'h6 |-> since_r == 4 * SETTLE_CYCLES + 1;
    endproperty
    a_gain_time: assert property (p_gain_time) else $error("gain calibration wrong length");
    property p_read_sets;
        dat_rd && afe_ctl.mod_reset |=> conv_ready_n;
    endproperty
    a_read_sets: assert property (p_read_sets) else $error("data read left ready flag low");
    property p_rdy_hold;
        !conv_ready_n && afe_ctl.mod_reset && !dat_rd && !ctl_wr |=> !conv_ready_n;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready flag lost without read");
    property p_single_stby;
        $fell(conv_ready_n) && last_mode_r == 4'h1 |-> afe_ctl.mod_reset && !afe_ctl.analog_pwr_en;
    endproperty
    a_single_stby: assert property (p_single_stby) else $error("no standby after single");
    property p_cal_idle;
        $fell(conv_ready_n) && last_mode_r inside {[4'h5:4'h8]} |-> afe_ctl.mod_reset && afe_ctl.mod_clk_en;
    endproperty
    a_cal_idle: assert property (p_cal_idle) else $error("no idle after calibration");
    property p_short;
        last_mode_r == 4'h5 && since_r inside {[1:SETTLE_CYCLES]} |-> afe_ctl.input_short;
    endproperty
    a_short: assert property (p_short) else $error("input not shorted in offset calibration");
    property p_fullscale;
        last_mode_r == 4'h6 && since_r inside {[1:4 * SETTLE_CYCLES]} |-> afe_ctl.fullscale_in;
    endproperty
    a_fullscale: assert property (p_fullscale) else $error("no full-scale input in gain calibration");
    property p_stby_pwr;
        ctl_wr && wmode == MODE_STANDBY |=> pwr_ctl == $past(pwr_w);
    endproperty
    a_stby_pwr: assert property (p_stby_pwr) else $error("standby power bits not applied");
    property p_pdown;
        ctl_wr && wmode == MODE_PDOWN |=> !afe_ctl.core_clk_en && !afe_ctl.analog_pwr_en && diag_run == '0;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down left circuitry running");
    property p_reserved;
        ctl_wr && wmode > 4'h8 |=> $stable(pwr_ctl);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode write took effect");
    c_single: cover property (ctl_wr && wmode == MODE_SINGLE);
    c_gain: cover property (ctl_wr && wmode == MODE_INT_GAIN);
    c_pdown: cover property (ctl_wr && wmode == MODE_PDOWN);
endmodule
bind aoms_seq aoms_seq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) aoms_seq_chk_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .conv_ready_n(conv_ready_n), .afe_ctl(afe_ctl), .pwr_ctl(pwr_ctl), .diag_run(diag_run));

// [tb/aoms_host.sv]
// host controller model: Avalon-MM master for the sequencer registers
`timescale 1ns/1ns
module aoms_host (
    input  wire logic        clk_sys,         // system clock
    output logic [7:0]       avs_address,     // byte address
    output logic             avs_read,        // read request
    output logic             avs_write,       // write request
    output logic [31:0]      avs_writedata,   // write data
    input  wire logic [31:0] avs_readdata,    // read data
    input  wire logic        avs_waitrequest  // stall while high
);
    initial begin
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end
    // holds the request until waitrequest is sampled low, then takes read data
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        // released data no longer shows the last value
        avs_writedata <= ~d;
    endtask
endmodule

// [tb/aoms_seq_tb.sv]
// self-checking bench for the operating mode sequencer
`timescale 1ns/1ns
`include "aoms_regs.svh"
module aoms_seq_tb;
    import aoms_pkg::*;
    localparam int SC = 4;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [23:0] adc_result = 24'h123456;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  adc_ch_sel;
    logic        conv_ready_n;
    aoms_afe_t   afe_ctl;
    aoms_pwr_t   pwr_ctl;
    logic [4:0]  diag_run;
    int          n_errors = 0;
    int          comparisons = 0;
    aoms_seq #(.NCH(4), .SETTLE_CYCLES(SC)) aoms_seq_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_result(adc_result),
        .adc_ch_sel(adc_ch_sel), .conv_ready_n(conv_ready_n), .afe_ctl(afe_ctl), .pwr_ctl(pwr_ctl),
        .diag_run(diag_run));
    aoms_host aoms_host_i (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        aoms_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        aoms_host_i.xfer(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic setmode(input logic [3:0] m, input logic [3:0] p);
        wr(`AOMS_CTRL_OFS, {20'h0, p, 2'b00, m, 2'b00});
    endtask
    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask
    // counts edges from the accepting edge until the ready flag is low
    task automatic wait_rdy(output int n);
        n = 0;
        do begin
            settle();
            n++;
        end while (conv_ready_n !== 1'b0);
    endtask
    task automatic t_reset();
        int n;
        rc("ctrl reset", `AOMS_CTRL_OFS, 32'h0);
        wait_rdy(n);
        rc("continuous data", `AOMS_DATA_OFS, 32'h123456);
    endtask
    task automatic t_single();
        int n;
        adc_result <= 24'hA5C3E1;
        setmode(MODE_SINGLE, 4'h0);
        wait_rdy(n);
        check("single time", n, SC);
        rc("standby after single", `AOMS_CTRL_OFS, 32'h8);
        adc_result <= 24'h0F0F0F;
        repeat (3) settle();
        check("ready held", conv_ready_n, 1'b0);
        rc("single data", `AOMS_DATA_OFS, 32'hA5C3E1);
        settle();
        check("ready after read", conv_ready_n, 1'b1);
    endtask
    task automatic t_standby();
        setmode(MODE_STANDBY, 4'hA);
        settle();
        check("pwr A", pwr_ctl, 4'hA);
        wr(`AOMS_CHSEL_OFS, 32'h2);
        wr(`AOMS_OFFS_BASE + 8'h8, 32'h00ABCD);
        wr(`AOMS_DIAG_OFS, 32'h1F);
        settle();
        check("diag in standby", diag_run, 5'h0);
        setmode(MODE_STANDBY, 4'h5);
        settle();
        check("pwr 5", pwr_ctl, 4'h5);
        rc("offset kept", `AOMS_OFFS_BASE + 8'h8, 32'h00ABCD);
        rc("chsel kept", `AOMS_CHSEL_OFS, 32'h2);
        check("channel out", adc_ch_sel, 32'h2);
    endtask
    task automatic t_cal();
        logic [3:0] m [4] = '{MODE_INT_GAIN, MODE_INT_OFS, MODE_SYS_OFS, MODE_SYS_GAIN};
        logic [7:0] a;
        int         n;
        wr(`AOMS_CHSEL_OFS, 32'h1);
        wr(`AOMS_OFFS_BASE + 8'h4, 32'h800000);
        for (int i = 0; i < 4; i++) begin
            adc_result <= 24'h3C0000 + 24'(i);
            a = (m[i] == MODE_INT_OFS || m[i] == MODE_SYS_OFS) ? `AOMS_OFFS_BASE + 8'h4 : `AOMS_GAIN_BASE + 8'h4;
            setmode(m[i], 4'h0); // gain above one and reduced power assumed at the host
            wait_rdy(n);
            check("cal time", n, m[i] == MODE_INT_GAIN ? 4 * SC : SC);
            rc("idle after cal", `AOMS_CTRL_OFS, 32'h10);
            rc("coefficient", a, {8'h0, 24'h3C0000 + 24'(i)});
        end
        check("idle clocks", {afe_ctl.mod_reset, afe_ctl.mod_clk_en}, 2'b11);
        wr(`AOMS_DIAG_OFS, 32'h0);
        wr(`AOMS_DIAG_OFS, 32'h1F);
        settle();
        check("diag in idle", diag_run, 5'h1F);
    endtask
    task automatic t_pdown();
        setmode(4'h9, 4'hF);
        rc("reserved ignored", `AOMS_CTRL_OFS, 32'h10);
        setmode(MODE_PDOWN, 4'h0);
        settle();
        check("clock stopped", afe_ctl.core_clk_en, 1'b0);
        setmode(MODE_STANDBY, 4'h0);
        rc("offset lost", `AOMS_OFFS_BASE + 8'h4, 32'h800000);
        rc("gain lost", `AOMS_GAIN_BASE + 8'h4, 32'h500000);
        wr(`AOMS_CHSEL_OFS, 32'h1);
        wr(`AOMS_OFFS_BASE + 8'h4, 32'h800000);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_single();
        t_standby();
        t_cal();
        t_pdown();
        test_done();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        test_done();
    end
endmodule
